// ===== psq_sequencer.sv
/*
 * psq_sequencer: power-state and reset sequencer of the display controller.
 * Assumes an spi decoder delivering one-cycle power commands, and that rst
 * is the power-on reset pulse from the core regulator.
 */
// What this block does
// RULE_01: after any reset sit in sleep; leave sleep only on active command; code also leaves sleep on standby or powerdown command.
// RULE_02: graphics, audio and touch engines enabled only in active state.
// RULE_03: power-down pin low forces powerdown from any state; commands enter low-power states.
// RULE_04: active runs oscillator and pll and enables core system clock.
// RULE_05: standby keeps oscillator and pll, gates core clock, keeps registers.
// RULE_06: sleep stops oscillator, pll and core clock, registers kept.
// RULE_07: powerdown stops clocks, removes core power, keeps spi command path alive.
// RULE_08: wake from powerdown only by active command while pin is high.
// RULE_09: after pin powerdown host raises pin, then sends active command.
// RULE_10: leaving powerdown does global reset and reboot; powerdown pin settings survive.
// RULE_11: host reruns clock select and enable sequence after powerdown wake.
// RULE_12: host waits 20 ms after sleep wake before any access.
// RULE_13: host may access immediately after standby wake.
// RULE_14: pin held low at least 5 ms then raised is a hardware reset.
// RULE_15: power-on reset pulse resets all core digital logic.
// RULE_16: soft reset, clock source switch and powerdown wake each reset device.
// RULE_17: boot starts clocks, waits, checks ram, configures, releases clock within 300 ms.
// RULE_18: active to standby or sleep keeps every pin level and direction.
// RULE_19: host sets audio and backlight to known levels before transitions.
// RULE_20: pin-level command sets powerdown pin behaviour, surviving wake reset.
// RULE_21: default powerdown pulls display, audio, backlight low; others float.
// RULE_22: during reset data-out floats with chip select high; irq output floats.
// RULE_23: low-power irq follows resistive touch or capacitive panel interrupt.
// RULE_24: power commands decoded in every state.
`timescale 1ns/100ps

module psq_sequencer
#(
    parameter int PD_HOLD_CYC    = psq_pkg::PD_HOLD_CYC,
    parameter int OSC_SETTLE_CYC = psq_pkg::OSC_SETTLE_CYC,
    parameter int RAM_CHECK_CYC  = psq_pkg::RAM_CHECK_CYC,
    parameter int CONFIG_CYC     = psq_pkg::CONFIG_CYC
)
(
    input  wire logic                              clk,
    input  wire logic                              rst,
    input  wire logic                              power_down_pin_n,
    input  wire logic                              spi_cs_n,
    input  wire logic                              touch_panel_irq_n,
    input  wire logic                              cmd_valid,
    input  wire psq_pkg::psq_cmd_t                 cmd_code,
    input  wire logic [psq_pkg::CMD_ARG_W-1:0]     cmd_arg,
    input  wire logic                              touch_is_cap,
    input  wire logic                              resist_touch,
    input  wire logic                              engine_irq,
    input  wire logic                              spi_miso_req,
    output logic                                   osc_en,
    output logic                                   pll_en,
    output logic                                   sys_clk_en,
    output logic                                   engines_en,
    output logic                                   core_power_en,
    output logic                                   core_rst,
    output logic                                   spi_if_en,
    output logic                                   clk_ext_sel,
    output logic                                   pin_hold,
    output logic                                   boot_busy,
    output logic [psq_pkg::PD_GROUPS-1:0]          pd_pull_low,
    output logic [psq_pkg::PD_GROUPS-1:0]          pd_float,
    output logic                                   host_irq_n_o,
    output logic                                   host_irq_n_oe,
    output logic                                   miso_oe,
    output psq_pkg::psq_state_t                    power_state
);

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic [2:0] pins_sync;
    logic       pd_pin_s;
    logic       cs_s;
    logic       tp_irq_s;

    psq_pin_sync #(.W(3)) u_pin_sync
    (
        .clk       (clk),
        .rst       (rst),
        .pin_async ({touch_panel_irq_n, spi_cs_n, power_down_pin_n}),
        .pin_sync  (pins_sync)
    );

    assign pd_pin_s = pins_sync[0];
    assign cs_s     = pins_sync[1];
    assign tp_irq_s = pins_sync[2];

    ////////////////////////////////////////////////////////////////////////
    // state and bookkeeping registers

    psq_pkg::psq_state_t                state_reg;
    psq_pkg::psq_state_t                state_next;
    logic [psq_pkg::CNT_W-1:0]          cnt_reg;
    logic [psq_pkg::CNT_W-1:0]          cnt_next;
    logic [psq_pkg::CNT_W-1:0]          pd_cnt_reg;
    logic [psq_pkg::CNT_W-1:0]          pd_cnt_next;
    logic                               pd_prev_reg;
    logic                               need_boot_reg;
    logic                               need_boot_next;
    logic                               clk_ext_reg;
    logic                               clk_ext_next;
    logic [psq_pkg::PD_GROUPS-1:0]      pd_cfg_reg;
    logic [psq_pkg::PD_GROUPS-1:0]      pd_cfg_next;

    ////////////////////////////////////////////////////////////////////////
    // command decode in every state; powerdown acts only on active and pin-level commands

    wire c_act   = cmd_valid && (cmd_code == psq_pkg::psq_cmd_active);      // RULE_24
    wire c_stby  = cmd_valid && (cmd_code == psq_pkg::psq_cmd_standby);
    wire c_slp   = cmd_valid && (cmd_code == psq_pkg::psq_cmd_sleep);
    wire c_pd    = cmd_valid && (cmd_code == psq_pkg::psq_cmd_powerdown);
    wire c_rst   = cmd_valid && (cmd_code == psq_pkg::psq_cmd_rst_pulse);
    wire c_cint  = cmd_valid && (cmd_code == psq_pkg::psq_cmd_clk_int);
    wire c_cext  = cmd_valid && (cmd_code == psq_pkg::psq_cmd_clk_ext);
    wire c_level = cmd_valid && (cmd_code == psq_pkg::psq_cmd_pd_pin_level);

    wire in_pd   = (state_reg == psq_pkg::psq_st_powerdown);

    // unpowered core ignores these in powerdown
    wire sw_rst  = (c_rst || c_cint || c_cext) && !in_pd;                    // RULE_16

    ////////////////////////////////////////////////////////////////////////
    // power-down pin as hardware reset

    wire pin_rise = pd_pin_s && !pd_prev_reg;
    wire pd_long  = (pd_cnt_reg == psq_pkg::CNT_W'(PD_HOLD_CYC));
    wire hw_rst   = pin_rise && pd_long;                                     // RULE_14

    // saturating low-time counter; clears as soon as the pin is high
    assign pd_cnt_next = pd_pin_s ? '0 :
                         pd_long  ? pd_cnt_reg :
                                    pd_cnt_reg + psq_pkg::CNT_W'(1);

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pd_cnt_reg  <= '0;
            pd_prev_reg <= 1'b1;
        end
        else
        begin
            pd_cnt_reg  <= pd_cnt_next;
            pd_prev_reg <= pd_pin_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // phase timer

    logic [psq_pkg::CNT_W-1:0] phase_len;

    assign phase_len = (state_reg == psq_pkg::psq_st_osc_wait)  ? psq_pkg::CNT_W'(OSC_SETTLE_CYC) :
                       (state_reg == psq_pkg::psq_st_ram_check) ? psq_pkg::CNT_W'(RAM_CHECK_CYC) :
                                                                  psq_pkg::CNT_W'(CONFIG_CYC);

    wire phase_done = (cnt_reg == phase_len - psq_pkg::CNT_W'(1));
    wire st_change  = (state_next != state_reg);

    assign cnt_next = st_change ? '0 : cnt_reg + psq_pkg::CNT_W'(1);

    ////////////////////////////////////////////////////////////////////////
    // power state machine

    wire lp_cmd = c_stby || c_slp || c_pd;

    psq_pkg::psq_state_t lp_state;

    assign lp_state = c_pd   ? psq_pkg::psq_st_powerdown :
                      c_stby ? psq_pkg::psq_st_standby :
                               psq_pkg::psq_st_sleep;

    always_comb
    begin
        state_next = state_reg;
        if (!pd_pin_s)
        begin
            state_next = psq_pkg::psq_st_powerdown;                          // RULE_03
        end
        else if (hw_rst || sw_rst)
        begin
            state_next = psq_pkg::psq_st_sleep;                              // RULE_01
        end
        else
        begin
            case (state_reg)
                psq_pkg::psq_st_active:
                begin
                    if (lp_cmd)
                        state_next = lp_state;                               // RULE_03
                end
                psq_pkg::psq_st_standby:
                begin
                    // oscillator already stable, so no settle wait
                    if (c_act)
                        state_next = need_boot_reg ? psq_pkg::psq_st_ram_check
                                                   : psq_pkg::psq_st_active;
                    else if (lp_cmd)
                        state_next = lp_state;
                end
                psq_pkg::psq_st_sleep:
                begin
                    if (c_act)
                        state_next = psq_pkg::psq_st_osc_wait;               // RULE_01
                    else if (lp_cmd)
                        state_next = lp_state;
                end
                psq_pkg::psq_st_powerdown:
                begin
                    // pin known high here
                    if (c_act)
                        state_next = psq_pkg::psq_st_osc_wait;               // RULE_08 RULE_10
                end
                psq_pkg::psq_st_osc_wait:
                begin
                    if (lp_cmd)
                        state_next = lp_state;
                    else if (phase_done)
                        state_next = need_boot_reg ? psq_pkg::psq_st_ram_check
                                                   : psq_pkg::psq_st_active;
                end
                psq_pkg::psq_st_ram_check:
                begin
                    if (lp_cmd)
                        state_next = lp_state;
                    else if (phase_done)
                        state_next = psq_pkg::psq_st_config;                 // RULE_17
                end
                psq_pkg::psq_st_config:
                begin
                    if (lp_cmd)
                        state_next = lp_state;
                    else if (phase_done)
                        state_next = psq_pkg::psq_st_active;                 // RULE_17
                end
                default:
                begin
                    state_next = psq_pkg::psq_st_sleep;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // reset bookkeeping and retained settings

    wire enter_pd  = (state_next == psq_pkg::psq_st_powerdown) && !in_pd;
    wire leave_pd  = in_pd && (state_next != psq_pkg::psq_st_powerdown);
    wire boot_done = (state_reg == psq_pkg::psq_st_config) &&
                     (state_next == psq_pkg::psq_st_active);

    // powerdown loses core state, so a wake always reboots
    assign need_boot_next = (hw_rst || sw_rst || enter_pd) ? 1'b1 :          // RULE_10 RULE_16
                            boot_done                      ? 1'b0 :
                                                             need_boot_reg;

    assign clk_ext_next = (hw_rst || leave_pd) ? 1'b0 :                      // RULE_10
                          (c_cext && !in_pd)   ? 1'b1 :
                          (c_cint && !in_pd)   ? 1'b0 :
                                                 clk_ext_reg;

    wire [psq_pkg::ARG_GRP_W-1:0] lvl_grp = cmd_arg[psq_pkg::ARG_GRP_LSB +: psq_pkg::ARG_GRP_W];
    wire                          lvl_low = cmd_arg[psq_pkg::ARG_LEVEL_BIT];

    genvar g;
    generate
        for (g = 0; g < psq_pkg::PD_GROUPS; g++)
        begin : g_pd_cfg
            // soft and wake resets keep these
            assign pd_cfg_next[g] = hw_rst ? psq_pkg::PD_LOW_DEFAULT[g] :             // RULE_20
                                    (c_level && lvl_grp == psq_pkg::ARG_GRP_W'(g)) ? lvl_low :
                                    pd_cfg_reg[g];
        end
    endgenerate

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_reg     <= psq_pkg::psq_st_sleep;                          // RULE_01 RULE_15
            cnt_reg       <= '0;
            need_boot_reg <= 1'b1;
            clk_ext_reg   <= 1'b0;
            pd_cfg_reg    <= psq_pkg::PD_LOW_DEFAULT;                        // RULE_21
        end
        else
        begin
            state_reg     <= state_next;
            cnt_reg       <= cnt_next;
            need_boot_reg <= need_boot_next;
            clk_ext_reg   <= clk_ext_next;
            pd_cfg_reg    <= pd_cfg_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs decoded from next state; data-out enable decoded from chip select and request

    wire n_act  = (state_next == psq_pkg::psq_st_active);
    wire n_stby = (state_next == psq_pkg::psq_st_standby);
    wire n_slp  = (state_next == psq_pkg::psq_st_sleep);
    wire n_pd   = (state_next == psq_pkg::psq_st_powerdown);
    wire n_boot = (state_next == psq_pkg::psq_st_osc_wait) ||
                  (state_next == psq_pkg::psq_st_ram_check) ||
                  (state_next == psq_pkg::psq_st_config);

    wire osc_next     = n_act || n_stby || n_boot;                           // RULE_04 RULE_05 RULE_06
    wire sysclk_next  = n_act;                                               // RULE_04 RULE_05
    wire engines_next = n_act && !need_boot_next;                            // RULE_02
    wire power_next   = !n_pd;                                               // RULE_07
    wire hold_next    = n_stby || n_slp;                                     // RULE_18

    wire [psq_pkg::PD_GROUPS-1:0] pull_next  = n_pd ? pd_cfg_next  : '0;     // RULE_20 RULE_21
    wire [psq_pkg::PD_GROUPS-1:0] float_next = n_pd ? ~pd_cfg_next : '0;     // RULE_21

    // open-drain host interrupt; floats while rst is high and in the boot states, but drives touch in standby and sleep and capacitive touch only in powerdown
    wire lp_touch   = touch_is_cap ? !tp_irq_s : resist_touch;
    wire irq_next   = n_act  ? (engine_irq && !need_boot_next) :
                      (n_stby || n_slp) ? lp_touch :                         // RULE_23
                      n_pd   ? (touch_is_cap && !tp_irq_s) :                 // RULE_23
                               1'b0;                                         // RULE_22

    // data-out only drives while selected, reset included
    wire miso_next  = spi_miso_req && !cs_s;                                 // RULE_22

    ////////////////////////////////////////////////////////////////////////
    // output registers

    logic                          osc_reg;
    logic                          sysclk_reg;
    logic                          engines_reg;
    logic                          power_reg;
    logic                          core_rst_reg;
    logic                          hold_reg;
    logic                          boot_reg;
    logic [psq_pkg::PD_GROUPS-1:0] pull_reg;
    logic [psq_pkg::PD_GROUPS-1:0] float_reg;
    logic                          irq_oe_reg;
    logic                          miso_reg;
    logic                          spi_en_reg;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            osc_reg      <= 1'b0;
            sysclk_reg   <= 1'b0;
            engines_reg  <= 1'b0;
            power_reg    <= 1'b1;
            core_rst_reg <= 1'b1;
            hold_reg     <= 1'b1;
            boot_reg     <= 1'b0;
        end
        else
        begin
            osc_reg      <= osc_next;
            sysclk_reg   <= sysclk_next;
            engines_reg  <= engines_next;
            power_reg    <= power_next;
            core_rst_reg <= need_boot_next;                                  // RULE_10 RULE_17
            hold_reg     <= hold_next;
            boot_reg     <= n_boot;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pull_reg   <= '0;
            float_reg  <= '0;
            irq_oe_reg <= 1'b0;
            miso_reg   <= 1'b0;
            spi_en_reg <= 1'b1;
        end
        else
        begin
            pull_reg   <= pull_next;
            float_reg  <= float_next;
            irq_oe_reg <= irq_next;
            miso_reg   <= miso_next;
            spi_en_reg <= 1'b1;                                              // RULE_07
        end
    end

    assign osc_en        = osc_reg;
    assign pll_en        = osc_reg;
    assign sys_clk_en    = sysclk_reg;
    assign engines_en    = engines_reg;
    assign core_power_en = power_reg;
    assign core_rst      = core_rst_reg;
    assign spi_if_en     = spi_en_reg;
    assign clk_ext_sel   = clk_ext_reg;
    assign pin_hold      = hold_reg;
    assign boot_busy     = boot_reg;
    assign pd_pull_low   = pull_reg;
    assign pd_float      = float_reg;
    assign host_irq_n_o  = 1'b0;
    assign host_irq_n_oe = irq_oe_reg;
    assign miso_oe       = miso_reg;
    assign power_state   = state_reg;

endmodule : psq_sequencer

// ===== psq_pkg.sv
/*
 * psq_pkg: shared types and constants of the power-state sequencer.
 * Assumes a single 100 MHz clock domain; times are converted to cycles here.
 */
package psq_pkg;

    typedef enum logic [2:0]
    {
        psq_st_active,
        psq_st_standby,
        psq_st_sleep,
        psq_st_powerdown,
        psq_st_osc_wait,
        psq_st_ram_check,
        psq_st_config
    } psq_state_t;

    // host power commands as delivered by the spi command decoder
    typedef enum logic [3:0]
    {
        psq_cmd_active,
        psq_cmd_standby,
        psq_cmd_sleep,
        psq_cmd_powerdown,
        psq_cmd_rst_pulse,
        psq_cmd_clk_int,
        psq_cmd_clk_ext,
        psq_cmd_pd_pin_level
    } psq_cmd_t;

    localparam int CLK_MHZ       = 100;
    localparam int US_PER_MS     = 1000;
    localparam int PD_HOLD_MS    = 5;
    localparam int OSC_SETTLE_MS = 10;
    localparam int RAM_CHECK_MS  = 100;
    localparam int CONFIG_MS     = 10;

    localparam int PD_HOLD_CYC    = PD_HOLD_MS * US_PER_MS * CLK_MHZ;
    localparam int OSC_SETTLE_CYC = OSC_SETTLE_MS * US_PER_MS * CLK_MHZ;
    localparam int RAM_CHECK_CYC  = RAM_CHECK_MS * US_PER_MS * CLK_MHZ;
    localparam int CONFIG_CYC     = CONFIG_MS * US_PER_MS * CLK_MHZ;

    localparam int CNT_W     = 32;
    localparam int CMD_ARG_W = 8;

    // pin groups steered in powerdown; groups 0..7 pull low by default
    localparam int PD_GROUPS     = 13;

    localparam logic [PD_GROUPS-1:0] PD_LOW_DEFAULT = 13'h00ff;

    // pin-level command argument: bit 0 = pull low, bits 4:1 = group
    localparam int ARG_LEVEL_BIT = 0;
    localparam int ARG_GRP_LSB   = 1;
    localparam int ARG_GRP_W     = 4;

endpackage : psq_pkg

// ===== psq_pin_sync.sv
/*
 * psq_pin_sync: three-stage synchroniser for asynchronous pins.
 * Assumes pins idle high; the output moves only when stages two and three agree.
 */
`timescale 1ns/100ps

module psq_pin_sync
#(
    parameter int W = 3
)
(
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] pin_async,
    output logic      [W-1:0] pin_sync
);

    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    logic [W-1:0] out_reg;
    logic [W-1:0] out_next;

    ////////////////////////////////////////////////////////////////////////
    // agreement filter: a single-cycle glitch between stages is ignored
    genvar g;
    generate
        for (g = 0; g < W; g++)
        begin : g_bit
            assign out_next[g] = (s2_reg[g] == s3_reg[g]) ? s3_reg[g] : out_reg[g];
        end
    endgenerate

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s1_reg  <= '1;
            s2_reg  <= '1;
            s3_reg  <= '1;
            out_reg <= '1;
        end
        else
        begin
            s1_reg  <= pin_async;
            s2_reg  <= s1_reg;
            s3_reg  <= s2_reg;
            out_reg <= out_next;
        end
    end

    assign pin_sync = out_reg;

endmodule : psq_pin_sync

// ===== psq_sequencer_asserts.sv
/* psq_sequencer_asserts: state, clock and boot checks on the sequencer ports.
   assumes a bind from the bench and the shortened boot counts. */
`timescale 1ns/100ps
module psq_sequencer_asserts
(
    input wire logic                clk, rst, power_down_pin_n, cmd_valid,
    input wire psq_pkg::psq_cmd_t   cmd_code,
    input wire logic                osc_en, pll_en, sys_clk_en, engines_en,
    input wire logic                core_power_en, spi_if_en, pin_hold, boot_busy,
    input wire psq_pkg::psq_state_t power_state
);
    wire act = power_state == psq_pkg::psq_st_active;
    wire sby = power_state == psq_pkg::psq_st_standby;
    wire slp = power_state == psq_pkg::psq_st_sleep;
    wire pdn = power_state == psq_pkg::psq_st_powerdown;
    // raw pin high only; the synchroniser lag is covered by the low-pin check
    wire go  = cmd_valid && power_down_pin_n;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    chk_engine_gate: assert property (engines_en |-> act) else $error("engines on outside active");
    chk_active_clocks: assert property (act |-> osc_en && pll_en && sys_clk_en) else $error("active clocks off");
    chk_standby_clocks: assert property (sby |-> osc_en && pll_en && !sys_clk_en && pin_hold)
        else $error("standby clocks wrong");
    chk_sleep_clocks: assert property (slp |-> !osc_en && !pll_en && !sys_clk_en && pin_hold)
        else $error("sleep clocks wrong");
    chk_powerdown_power: assert property (pdn |-> !core_power_en && !osc_en && spi_if_en)
        else $error("powerdown power wrong");
    chk_pin_forces_pd: assert property (!power_down_pin_n [*7] |-> pdn) else $error("pin low not powerdown");
    chk_sleep_wake: assert property (slp && go && cmd_code == psq_pkg::psq_cmd_active |=> osc_en && boot_busy)
        else $error("sleep wake missed");
    chk_sleep_cmd: assert property (act && go && cmd_code == psq_pkg::psq_cmd_sleep |=> slp)
        else $error("sleep command missed");
    chk_boot_bound: assert property ($rose(boot_busy) |-> ##[1:40] !boot_busy) else $error("boot too long");
endmodule : psq_sequencer_asserts

// ===== psq_host_model.sv
/* psq_host_model: host side of the power interface, commands and the pin.
   assumes the bench calls its tasks; drives on the falling edge. */
`timescale 1ns/100ps
module psq_host_model
(
    input  wire logic                     clk,
    output logic                          cmd_valid = 1'h0,
    output psq_pkg::psq_cmd_t             cmd_code = psq_pkg::psq_cmd_active,
    output logic [psq_pkg::CMD_ARG_W-1:0] cmd_arg = 8'h00,
    output logic                          power_down_pin_n = 1'h1
);
    // one-cycle pulse
    task automatic send(input psq_pkg::psq_cmd_t c, input logic [7:0] a);
        @(negedge clk);
        cmd_valid = 1'h1;
        cmd_code = c;
        cmd_arg = a;
        @(negedge clk);
        cmd_valid = 1'h0;
    endtask : send
    task automatic pin(input logic v, input int n);
        @(negedge clk);
        power_down_pin_n = v;
        repeat (n) @(negedge clk);
    endtask : pin
endmodule : psq_host_model

// ===== psq_sequencer_tb.sv
/* psq_sequencer_tb: directed power-state scenarios through the host model.
   assumes 100 MHz clk and shortened boot and pin-hold counts. */
`timescale 1ns/100ps
module psq_sequencer_tb;
    logic clk = 1'h0, rst = 1'h1, spi_cs_n = 1'h1, touch_panel_irq_n = 1'h1, touch_is_cap = 1'h0;
    logic resist_touch = 1'h0, engine_irq = 1'h0, spi_miso_req = 1'h0, cmd_valid, power_down_pin_n;
    logic osc_en, sys_clk_en, engines_en, core_power_en, core_rst, clk_ext_sel, host_irq_n_oe, miso_oe;
    logic [7:0] cmd_arg;
    logic [psq_pkg::PD_GROUPS-1:0] pd_pull_low, pd_float;
    psq_pkg::psq_cmd_t cmd_code;
    psq_pkg::psq_state_t power_state;
    int err_total = 0, compares = 0;
    always #5 clk = ~clk;
    psq_host_model h (.clk, .cmd_valid, .cmd_code, .cmd_arg, .power_down_pin_n);
    psq_sequencer #(.PD_HOLD_CYC(20), .OSC_SETTLE_CYC(8), .RAM_CHECK_CYC(8), .CONFIG_CYC(4)) psq_sequencer_inst
    (.clk, .rst, .power_down_pin_n, .spi_cs_n, .touch_panel_irq_n, .cmd_valid, .cmd_code, .cmd_arg, .touch_is_cap,
     .resist_touch, .engine_irq, .spi_miso_req, .osc_en, .pll_en(), .sys_clk_en, .engines_en, .core_power_en,
     .core_rst, .spi_if_en(), .clk_ext_sel, .pin_hold(), .boot_busy(), .pd_pull_low, .pd_float, .host_irq_n_o(),
     .host_irq_n_oe, .miso_oe, .power_state);
    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        compares++;
        if (s !== e)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic stop_test;
        $display("checks %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : stop_test
    task automatic wait_st(input psq_pkg::psq_state_t s);
        for (int i = 0; i < 64 && power_state !== s; i++)
            @(negedge clk);
        chk("wait", power_state, s);
        if (power_state !== s)
            stop_test;
    endtask : wait_st
    task automatic t_boot;
        chk("state", power_state, psq_pkg::psq_st_sleep);
        chk("core_rst", core_rst, 1'h1);
        h.send(psq_pkg::psq_cmd_active, 8'h00);
        chk("osc", osc_en, 1'h1);
        wait_st(psq_pkg::psq_st_active);
        chk("engines", engines_en, 1'h1);
        chk("core_rst", core_rst, 1'h0);
        $display("test boot done");
    endtask : t_boot
    task automatic t_low;
        spi_cs_n = 1'h0;
        spi_miso_req = 1'h1;
        h.send(psq_pkg::psq_cmd_standby, 8'h00);
        chk("state", power_state, psq_pkg::psq_st_standby);
        chk("engines", engines_en, 1'h0);
        h.send(psq_pkg::psq_cmd_active, 8'h00);
        chk("state", power_state, psq_pkg::psq_st_active);
        h.send(psq_pkg::psq_cmd_sleep, 8'h00);
        resist_touch = 1'h1;
        repeat (3) @(negedge clk);
        chk("irq", host_irq_n_oe, 1'h1);
        chk("miso", miso_oe, 1'h1);
        spi_cs_n = 1'h1;
        resist_touch = 1'h0;
        h.send(psq_pkg::psq_cmd_active, 8'h00);
        wait_st(psq_pkg::psq_st_active);
        chk("miso", miso_oe, 1'h0);
        $display("test low done");
    endtask : t_low
    task automatic t_pd;
        h.send(psq_pkg::psq_cmd_pd_pin_level, 8'h11);
        h.pin(1'h0, 10);
        chk("pull", pd_pull_low, 13'h01ff);
        chk("float", pd_float, 13'h1e00);
        h.send(psq_pkg::psq_cmd_standby, 8'h00);
        chk("state", power_state, psq_pkg::psq_st_powerdown);
        h.send(psq_pkg::psq_cmd_active, 8'h00);
        chk("state", power_state, psq_pkg::psq_st_powerdown);
        h.pin(1'h1, 6);
        h.send(psq_pkg::psq_cmd_active, 8'h00);
        wait_st(psq_pkg::psq_st_active);
        h.send(psq_pkg::psq_cmd_powerdown, 8'h00);
        chk("pull", pd_pull_low, 13'h01ff);
        h.send(psq_pkg::psq_cmd_active, 8'h00);
        wait_st(psq_pkg::psq_st_active);
        h.pin(1'h0, 30);
        h.pin(1'h1, 6);
        chk("state", power_state, psq_pkg::psq_st_sleep);
        $display("test pd done");
    endtask : t_pd
    task automatic t_soft;
        for (int k = 4; k < 7; k++)
        begin
            h.send(psq_pkg::psq_cmd_t'(k), 8'h00);
            chk("state", power_state, psq_pkg::psq_st_sleep);
            chk("clk_ext", clk_ext_sel, k == 6);
            h.send(psq_pkg::psq_cmd_active, 8'h00);
            wait_st(psq_pkg::psq_st_active);
        end
        $display("test soft done");
    endtask : t_soft
    initial
    begin
        repeat (10) @(negedge clk);
        rst = 1'h0;
        t_boot;
        t_low;
        t_pd;
        t_soft;
        stop_test;
    end
endmodule : psq_sequencer_tb
bind psq_sequencer psq_sequencer_asserts psq_sequencer_asserts_inst (.clk, .rst, .power_down_pin_n, .cmd_valid,
    .cmd_code, .osc_en, .pll_en, .sys_clk_en, .engines_en, .core_power_en, .spi_if_en, .pin_hold, .boot_busy,
    .power_state);
